//--- design/slc_pkg.sv
package slc_pkg;
  // Line rate derivation
  localparam int unsigned SLC_RATE_NUM = 153600;
  localparam int unsigned SLC_CLK_HZ = 250000000;
  localparam int unsigned SLC_BIT_CYC_UNIT = SLC_CLK_HZ / SLC_RATE_NUM;
  localparam logic [15:0] SLC_RATE_RESET = 16'h2580;
  localparam int unsigned SLC_RATE_MAX = 76800;
  // Message opcodes
  localparam logic [7:0] SLC_OP_CONFIG = 8'h04;
  localparam logic [7:0] SLC_OP_XMIT = 8'h05;
  localparam logic [7:0] SLC_OP_ABORT = 8'h06;
  localparam logic [7:0] SLC_OP_SUSPEND = 8'h07;
  localparam logic [7:0] SLC_OP_RESUME = 8'h08;
  localparam logic [7:0] SLC_OP_ENABLE = 8'h02;
  localparam logic [7:0] SLC_OP_DISABLE = 8'h03;
  localparam logic [7:0] SLC_OP_SETBRK = 8'h11;
  localparam logic [7:0] SLC_OP_CLRBRK = 8'h12;
  localparam logic [7:0] SLC_RSP_XDONE = 8'h01;
  localparam logic [7:0] SLC_RSP_AUTOBAUD = 8'h02;
  localparam logic [7:0] SLC_RSP_SPECIAL = 8'h03;
  localparam int unsigned SLC_MSG_BYTES = 16;
  // Configure and transmit message byte positions
  localparam int unsigned SLC_B_RATE_LO = 2;
  localparam int unsigned SLC_B_RATE_HI = 3;
  localparam int unsigned SLC_B_LINK = 4;
  localparam int unsigned SLC_B_MODE = 6;
  localparam int unsigned SLC_B_HIGH = 7;
  localparam int unsigned SLC_B_LOW = 8;
  localparam int unsigned SLC_B_SIGMARK = 9;
  localparam int unsigned SLC_B_XON = 10;
  localparam int unsigned SLC_B_XOFF = 11;
  localparam int unsigned SLC_B_SPC0 = 12;
  localparam int unsigned SLC_B_SIZE_LO = 2;
  localparam int unsigned SLC_B_SIZE_HI = 3;
  localparam int unsigned SLC_B_ADDR_LO = 4;
  localparam int unsigned SLC_B_ADDR_HI = 5;
  // Link parameter fields and reset values
  localparam int unsigned SLC_F_PAR = 0;
  localparam int unsigned SLC_F_LEN = 2;
  localparam int unsigned SLC_F_STOP = 4;
  localparam logic [7:0] SLC_LINK_RESET = 8'h0a;
  localparam logic [7:0] SLC_MODE_RESET = 8'h00;
  localparam int unsigned SLC_M_THROT = 0;
  localparam int unsigned SLC_M_SIGNAL = 1;
  localparam int unsigned SLC_M_PAUSE = 2;
  localparam logic [7:0] SLC_XON_RESET = 8'h11;
  localparam logic [7:0] SLC_XOFF_RESET = 8'h13;
  localparam int unsigned SLC_MARK_SHIFT = 3;
  localparam int unsigned SLC_RXBUF_DEPTH = 2048;
  localparam int unsigned SLC_CNT_W = 12;
  // Transmit and receive engine states
  typedef enum logic [2:0] {
    SLC_TX_IDLE = 3'b000,
    SLC_TX_FETCH = 3'b001,
    SLC_TX_START = 3'b011,
    SLC_TX_DATA = 3'b010,
    SLC_TX_PAR = 3'b110,
    SLC_TX_STOP = 3'b111
  } slc_tx_t;
  typedef enum logic [2:0] {
    SLC_RX_IDLE = 3'b000,
    SLC_RX_START = 3'b001,
    SLC_RX_DATA = 3'b011,
    SLC_RX_PAR = 3'b010,
    SLC_RX_STOP = 3'b110
  } slc_rx_t;
endpackage

//--- design/slc_line.sv
`timescale 1ns/10ps
module slc_line (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic msg_valid_in,
  input wire logic [127:0] msg_in,
  output logic msg_ready_out,
  output logic rsp_valid_out,
  output logic [127:0] rsp_out,
  input wire logic mem_data_valid_in,
  input wire logic [7:0] mem_data_in,
  output logic mem_rd_out,
  output logic [15:0] mem_addr_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic rx_take_in,
  output logic [11:0] rx_count_out,
  input wire logic rxd_in,
  output logic txd_out
);
  import slc_pkg::*;

  // Rate count with a 32-bit divider; a rate that does not divide 153600 comes out faster
  function automatic logic [15:0] rate_count(input logic [15:0] r);
    logic [31:0] q;
    q = 32'(SLC_RATE_NUM) / 32'(r);
    rate_count = 16'(q - 32'd2);
  endfunction
  function automatic logic [7:0] lane(input logic [127:0] m,
                                      input int unsigned i);
    lane = m[i*8 +: 8];
  endfunction
  function automatic logic [7:0] mask_len(input logic [7:0] d,
                                          input logic [1:0] len);
    case (len)
      2'b00: mask_len = {2'b00, d[5:0]};
      2'b10: mask_len = {1'b0, d[6:0]};
      default: mask_len = d;
    endcase
  endfunction

  // Configuration state
  logic [15:0] rate_cnt, auto_cnt;
  logic [7:0] link, mode, hi_mark, lo_mark, sig_mark, xon_ch, xoff_ch;
  logic [31:0] spc;
  logic autobaud, enabled, breaking;
  logic [1:0] sync_rx;
  logic rxs, rxs_d;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sync_rx <= 2'b11;
      rxs_d <= 1'b1;
    end else if (ce_in) begin
      sync_rx <= {sync_rx[0], rxd_in};
      rxs_d <= sync_rx[1];
    end
  end
  assign rxs = sync_rx[1];

  wire [1:0] par_sel = link[SLC_F_PAR +: 2];
  wire par_on = par_sel[1];
  wire par_odd = par_sel[0];
  wire [1:0] len_sel = link[SLC_F_LEN +: 2];
  wire [3:0] nbits = (len_sel == 2'b00) ? 4'd6 :
                     (len_sel == 2'b10) ? 4'd7 : 4'd8;
  wire [1:0] stop_sel = link[SLC_F_STOP +: 2];
  // Bit period: cycles per unit times (count+2)
  wire [31:0] bit_cyc = 32'(SLC_BIT_CYC_UNIT) * (32'(rate_cnt) + 32'd2);
  wire [31:0] stop_cyc = (stop_sel == 2'b01) ? bit_cyc + (bit_cyc >> 1) :
                         (stop_sel == 2'b10) ? bit_cyc << 1 : bit_cyc;
  wire [12:0] hi_thr = {2'b00, hi_mark, 3'b000};
  wire [12:0] lo_thr = {2'b00, lo_mark, 3'b000};
  wire [12:0] sig_thr = {2'b00, sig_mark, 3'b000};

  wire [7:0] op = lane(msg_in, 0);
  wire take = msg_valid_in & msg_ready_out & ce_in;
  wire [15:0] req_rate = {lane(msg_in, SLC_B_RATE_HI),
                          lane(msg_in, SLC_B_RATE_LO)};

  // Transmit engine
  slc_tx_t tx_st;
  logic [15:0] tx_left, tx_addr;
  logic [7:0] tx_byte;
  logic [3:0] tx_bit;
  logic tx_par, paused_cmd, paused_flow, ctl_pend, ctl_sending;
  logic [7:0] ctl_ch;
  logic [31:0] tx_tmr;
  logic throttled;
  logic tx_busy;
  wire tx_tick = (tx_tmr == 32'd0);
  wire tx_fin = tx_tick & tx_busy & ~ctl_sending & (tx_left == 16'h0) &
                (tx_st == SLC_TX_STOP);
  wire tx_paused = paused_cmd | (paused_flow & mode[SLC_M_PAUSE]);
  assign msg_ready_out = ~rsp_valid_out;
  assign mem_rd_out = (tx_st == SLC_TX_FETCH) & ~mem_data_valid_in;
  assign mem_addr_out = tx_addr;

  // Receive side
  slc_rx_t rx_st;
  logic [31:0] rx_tmr;
  logic [3:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_pbit;
  logic [7:0] mem [SLC_RXBUF_DEPTH];
  logic [10:0] wp, rp;
  logic [11:0] cnt;
  logic [2:0] u_seen;
  logic [31:0] low_run;
  wire rx_tick = (rx_tmr == 32'd0);
  wire [7:0] rx_data = mask_len(rx_sh, len_sel);
  wire rx_par_ok = ~par_on | ((^rx_data ^ rx_pbit) == par_odd);
  wire [7:0] rx_hi_ones = (len_sel == 2'b00) ? 8'hc0 :
                          (len_sel == 2'b10) ? 8'h80 : 8'h00;
  wire [7:0] rx_pass = (len_sel == 2'b00) ? {1'b1, rx_pbit & par_on, 6'h00} :
                       (len_sel == 2'b10) ? {rx_pbit & par_on, 7'h00} :
                       8'h00;
  wire [7:0] rx_store_ok = rx_data | (par_on ? rx_pass : rx_hi_ones);
  wire is_spc = (mask_len(spc[7:0], len_sel) == rx_data) |
                (mask_len(spc[15:8], len_sel) == rx_data) |
                (mask_len(spc[23:16], len_sel) == rx_data) |
                (mask_len(spc[31:24], len_sel) == rx_data);
  wire rx_done = (rx_st == SLC_RX_STOP) & rx_tick & ~autobaud;
  wire frame_ok = rxs;
  wire store = rx_done & (~frame_ok | rx_par_ok) &
               (cnt < 12'(SLC_RXBUF_DEPTH));
  wire [7:0] store_byte = frame_ok ? rx_store_ok : 8'h00;
  wire pop = rx_take_in & (cnt != 12'h000);
  assign rx_valid_out = (cnt != 12'h000);
  assign rx_count_out = cnt;

  // Message handling, configuration and responses
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rate_cnt <= rate_count(SLC_RATE_RESET);
      link <= SLC_LINK_RESET;
      mode <= SLC_MODE_RESET;
      hi_mark <= 8'hff;
      lo_mark <= 8'h00;
      sig_mark <= 8'h00;
      xon_ch <= SLC_XON_RESET;
      xoff_ch <= SLC_XOFF_RESET;
      spc <= 32'h0;
      autobaud <= 1'b0;
      enabled <= 1'b0;
      breaking <= 1'b0;
      paused_cmd <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_out <= 128'h0;
    end else if (ce_in) begin
      rsp_valid_out <= 1'b0;
      if (take) begin
        case (op)
          SLC_OP_CONFIG: begin
            link <= lane(msg_in, SLC_B_LINK);
            mode <= lane(msg_in, SLC_B_MODE);
            hi_mark <= lane(msg_in, SLC_B_HIGH);
            lo_mark <= lane(msg_in, SLC_B_LOW);
            sig_mark <= lane(msg_in, SLC_B_SIGMARK);
            xon_ch <= lane(msg_in, SLC_B_XON);
            xoff_ch <= lane(msg_in, SLC_B_XOFF);
            spc <= msg_in[SLC_B_SPC0*8 +: 32];
            autobaud <= (req_rate == 16'h0000);
            if (req_rate != 16'h0000 && 32'(req_rate) <= SLC_RATE_MAX)
              rate_cnt <= rate_count(req_rate);
            paused_cmd <= 1'b0;
          end
          SLC_OP_ENABLE: enabled <= 1'b1;
          SLC_OP_DISABLE: enabled <= 1'b0;
          SLC_OP_SETBRK: breaking <= ~tx_busy;
          SLC_OP_CLRBRK: breaking <= 1'b0;
          SLC_OP_SUSPEND: if (tx_busy) paused_cmd <= 1'b1;
          SLC_OP_RESUME: if (tx_busy) paused_cmd <= 1'b0;
          SLC_OP_ABORT: begin
            if (tx_busy) begin
              rsp_valid_out <= 1'b1;
              rsp_out <= {120'h0, SLC_RSP_XDONE};
              paused_cmd <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      if (autobaud && u_seen == 3'd2) begin
        autobaud <= 1'b0;
        rate_cnt <= 16'(32'(auto_cnt) - 32'd2);
        rsp_valid_out <= 1'b1;
        rsp_out <= {112'h0, auto_cnt[7:0], SLC_RSP_AUTOBAUD};
      end else if (tx_fin) begin
        rsp_valid_out <= 1'b1;
        rsp_out <= {120'h0, SLC_RSP_XDONE};
      end else if (store && mode[SLC_M_SIGNAL] && is_spc &&
                   {1'b0, cnt} > sig_thr) begin
        rsp_valid_out <= 1'b1;
        rsp_out <= {112'h0, rx_data, SLC_RSP_SPECIAL};
      end
    end
  end

  // Transmit sequencer, including throttle characters
  wire start_ok = take & (op == SLC_OP_XMIT) & enabled & ~breaking &
                  ~autobaud & ~tx_busy;
  wire abort_now = take & (op == SLC_OP_ABORT) & tx_busy;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_st <= SLC_TX_IDLE;
      tx_left <= 16'h0;
      tx_addr <= 16'h0;
      tx_byte <= 8'h0;
      tx_bit <= 4'h0;
      tx_par <= 1'b0;
      tx_tmr <= 32'd0;
      txd_out <= 1'b1;
      ctl_sending <= 1'b0;
      tx_busy <= 1'b0;
    end else if (ce_in) begin
      if (tx_tmr != 32'd0)
        tx_tmr <= tx_tmr - 32'd1;
      if (start_ok) begin
        tx_left <= {lane(msg_in, SLC_B_SIZE_HI), lane(msg_in, SLC_B_SIZE_LO)};
        tx_addr <= {lane(msg_in, SLC_B_ADDR_HI), lane(msg_in, SLC_B_ADDR_LO)};
        tx_busy <= |{lane(msg_in, SLC_B_SIZE_HI), lane(msg_in, SLC_B_SIZE_LO)};
      end else if (abort_now || tx_fin) begin
        tx_left <= 16'h0;
        tx_busy <= 1'b0;
      end
      case (tx_st)
        SLC_TX_IDLE: begin
          txd_out <= ~breaking;
          if (ctl_pend) begin
            tx_byte <= ctl_ch;
            ctl_sending <= 1'b1;
            tx_st <= SLC_TX_START;
            tx_tmr <= bit_cyc - 32'd1;
          end else if (tx_left != 16'h0 && !tx_paused && !abort_now) begin
            tx_st <= SLC_TX_FETCH;
          end
        end
        SLC_TX_FETCH: begin
          if (abort_now) tx_st <= SLC_TX_IDLE;
          else if (mem_data_valid_in) begin
            tx_byte <= mask_len(mem_data_in, len_sel);
            tx_addr <= tx_addr + 16'h1;
            tx_left <= tx_left - 16'h1;
            ctl_sending <= 1'b0;
            tx_st <= SLC_TX_START;
            tx_tmr <= bit_cyc - 32'd1;
          end
        end
        SLC_TX_START: begin
          txd_out <= 1'b0;
          tx_par <= par_odd;
          tx_bit <= 4'h0;
          if (tx_tick) begin
            tx_st <= SLC_TX_DATA;
            tx_tmr <= bit_cyc - 32'd1;
          end
        end
        SLC_TX_DATA: begin
          txd_out <= tx_byte[tx_bit[2:0]];
          if (tx_tick) begin
            tx_par <= tx_par ^ tx_byte[tx_bit[2:0]];
            tx_bit <= tx_bit + 4'h1;
            tx_tmr <= bit_cyc - 32'd1;
            if (tx_bit + 4'h1 == nbits)
              tx_st <= par_on ? SLC_TX_PAR : SLC_TX_STOP;
          end
        end
        SLC_TX_PAR: begin
          txd_out <= tx_par;
          if (tx_tick) begin
            tx_st <= SLC_TX_STOP;
            tx_tmr <= stop_cyc - 32'd1;
          end
        end
        SLC_TX_STOP: begin
          txd_out <= 1'b1;
          if (tx_tick) begin
            tx_st <= SLC_TX_IDLE;
            ctl_sending <= 1'b0;
          end
        end
        default: tx_st <= SLC_TX_IDLE;
      endcase
    end
  end

  // Receive framer, buffer, throttle and flow response
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_st <= SLC_RX_IDLE;
      rx_tmr <= 32'd0;
      rx_bit <= 4'h0;
      rx_sh <= 8'h0;
      rx_pbit <= 1'b0;
      wp <= 11'h0;
      rp <= 11'h0;
      cnt <= 12'h0;
      rx_data_out <= 8'h0;
      throttled <= 1'b0;
      ctl_pend <= 1'b0;
      ctl_ch <= 8'h0;
      paused_flow <= 1'b0;
      u_seen <= 3'd0;
      auto_cnt <= 16'h0;
      low_run <= 32'd0;
    end else if (ce_in) begin
      if (rx_tmr != 32'd0)
        rx_tmr <= rx_tmr - 32'd1;
      case (rx_st)
        SLC_RX_IDLE: if (rxs_d && !rxs) begin
          rx_st <= SLC_RX_START;
          rx_tmr <= (bit_cyc >> 1) - 32'd1;
        end
        SLC_RX_START: if (rx_tick) begin
          rx_st <= rxs ? SLC_RX_IDLE : SLC_RX_DATA;
          rx_tmr <= bit_cyc - 32'd1;
          rx_bit <= 4'h0;
          rx_sh <= 8'h0;
        end
        SLC_RX_DATA: if (rx_tick) begin
          rx_sh[rx_bit[2:0]] <= rxs;
          rx_bit <= rx_bit + 4'h1;
          rx_tmr <= bit_cyc - 32'd1;
          if (rx_bit + 4'h1 == nbits)
            rx_st <= par_on ? SLC_RX_PAR : SLC_RX_STOP;
        end
        SLC_RX_PAR: if (rx_tick) begin
          rx_pbit <= rxs;
          rx_st <= SLC_RX_STOP;
          rx_tmr <= bit_cyc - 32'd1;
        end
        SLC_RX_STOP: if (rx_tick) rx_st <= SLC_RX_IDLE;
        default: rx_st <= SLC_RX_IDLE;
      endcase
      // Autobaud: a U gives alternating bits, shortest low run is one bit
      if (autobaud) begin
        low_run <= rxs ? 32'd0 : low_run + 32'd1;
        if (!rxs_d && rxs && low_run != 32'd0) begin
          if (u_seen < 3'd2) u_seen <= u_seen + 3'd1;
          auto_cnt <= 16'((low_run + 32'd1) / 32'(SLC_BIT_CYC_UNIT));
        end
      end else
        u_seen <= 3'd0;
      if (store) begin
        mem[wp] <= store_byte;
        wp <= wp + 11'h1;
      end
      if (pop) begin
        rx_data_out <= mem[rp];
        rp <= rp + 11'h1;
      end
      cnt <= cnt + {11'h0, store} - {11'h0, pop};
      // Throttle: XOFF at high mark, XON back at low mark
      if (ctl_pend && tx_st == SLC_TX_IDLE) ctl_pend <= 1'b0;
      if (mode[SLC_M_THROT]) begin
        if (store && !throttled && {1'b0, cnt + 12'h1} >= hi_thr) begin
          throttled <= 1'b1;
          ctl_pend <= 1'b1;
          ctl_ch <= xoff_ch;
        end else if (throttled && pop && {1'b0, cnt - 12'h1} == lo_thr) begin
          throttled <= 1'b0;
          ctl_pend <= 1'b1;
          ctl_ch <= xon_ch;
        end
      end else
        throttled <= 1'b0;
      if (rx_done && frame_ok && rx_par_ok) begin
        if (rx_data == mask_len(xoff_ch, len_sel)) paused_flow <= 1'b1;
        if (rx_data == mask_len(xon_ch, len_sel)) paused_flow <= 1'b0;
      end
    end
  end
endmodule

//--- testbench/slc_line_assertions.sv
`timescale 1ns/10ps
module slc_line_chk
  import slc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic msg_valid_in,
  input wire logic [127:0] msg_in,
  input wire logic msg_ready_out,
  input wire logic rsp_valid_out,
  input wire logic [127:0] rsp_out,
  input wire logic mem_data_valid_in,
  input wire logic mem_rd_out,
  input wire logic rx_valid_out,
  input wire logic [11:0] rx_count_out,
  input wire logic txd_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic busy;
  logic xmit_prev;
  // Message decode as seen from the host side
  wire take = msg_valid_in && msg_ready_out && ce_in;
  wire [7:0] op = msg_in[7:0];
  wire clr_take = take && (op == SLC_OP_CONFIG || op == SLC_OP_DISABLE);
  wire xdone = rsp_valid_out && rsp_out[7:0] == SLC_RSP_XDONE;
  // Busy from the first fetch until transmit complete shows
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      busy <= 1'h0;
      xmit_prev <= 1'h0;
    end else begin
      xmit_prev <= take && op == SLC_OP_XMIT;
      if (mem_rd_out)
        busy <= 1'h1;
      else if (xdone)
        busy <= 1'h0;
    end
  end
  a_reset_idle: assert property ($fell(rst_in) |-> txd_out
    && !rsp_valid_out && !rx_valid_out) else $error("not idle after reset");
  a_rsp_one_cycle: assert property (rsp_valid_out |=> !rsp_valid_out)
    else $error("response longer than one cycle");
  a_ready_vs_rsp: assert property (msg_ready_out != rsp_valid_out)
    else $error("ready does not follow response");
  a_abort_answer: assert property (take && op == SLC_OP_ABORT && busy
    |=> xdone) else $error("abort gave no transmit complete");
  a_abort_idle: assert property (take && op == SLC_OP_ABORT && !busy
    && !mem_rd_out && !xmit_prev |=> !rsp_valid_out)
    else $error("idle abort answered");
  a_pause_silent: assert property (take && (op == SLC_OP_SUSPEND
    || op == SLC_OP_RESUME) |=> !rsp_valid_out)
    else $error("suspend or resume answered");
  a_rx_valid_count: assert property (rx_valid_out == (rx_count_out != 0))
    else $error("buffer flag disagrees with count");
  a_count_step: assert property ($changed(rx_count_out)
    && !$past(clr_take) |-> (rx_count_out - $past(rx_count_out))
    inside {12'h001, 12'hfff}) else $error("count jumped");
  a_fetch_start: assert property ($fell(mem_rd_out) && mem_data_valid_in
    |-> ##[1:3] !txd_out) else $error("no start bit after fetch");
  c_xdone: cover property (xdone);
  c_abort_busy: cover property (take && op == SLC_OP_ABORT && busy);
  c_store: cover property (rx_count_out > $past(rx_count_out));
endmodule

//--- testbench/slc_remote.sv
`timescale 1ns/10ps
module slc_remote #(
  parameter int BIT_CYC = 3254
) (
  input wire logic clock_in,
  input wire logic txd_in,
  output logic rxd_out
);
  int rx_n = 7;
  int rx_cnt = 0;
  logic [7:0] rx_word = 8'h00;
  logic rx_stop = 1'h0;
  initial rxd_out = 1'h1;
  // Sends start, n bits low first, then the given stop level
  task automatic send_frame(input logic [8:0] bits, input int n,
                            input logic stop);
    rxd_out <= 1'h0;
    repeat (BIT_CYC) @(posedge clock_in);
    for (int i = 0; i < n; i++) begin
      rxd_out <= bits[i];
      repeat (BIT_CYC) @(posedge clock_in);
    end
    rxd_out <= stop;
    repeat (BIT_CYC) @(posedge clock_in);
    rxd_out <= 1'h1; // Line rests at mark level
  endtask
  // Samples each frame on the line in the middle of every bit
  always begin
    @(negedge txd_in);
    repeat (BIT_CYC / 2) @(posedge clock_in);
    if (txd_in === 1'h0) begin
      for (int i = 0; i < rx_n; i++) begin
        repeat (BIT_CYC) @(posedge clock_in);
        rx_word[i] = txd_in;
      end
      repeat (BIT_CYC) @(posedge clock_in);
      rx_stop = txd_in;
      rx_cnt++;
    end
  end
endmodule

//--- testbench/tb.sv
`timescale 1ns/10ps
module tb;
  import slc_pkg::*;
  localparam int RATE = 65535;
  localparam int BIT_CYC = (SLC_RATE_NUM / RATE - 2 + 2) * SLC_BIT_CYC_UNIT;
  logic clock_in = 1'h0;
  logic rst_in = 1'h1;
  logic ce_in = 1'h1;
  logic msg_valid_in = 1'h0;
  logic [127:0] msg_in = 128'h0;
  logic mem_data_valid_in = 1'h0;
  logic [7:0] mem_data_in = 8'h00;
  logic rx_take_in = 1'h0;
  logic msg_ready_out, rsp_valid_out, mem_rd_out, rx_valid_out;
  logic txd_out, rxd_in;
  logic [127:0] rsp_out;
  logic [15:0] mem_addr_out;
  logic [15:0] addr_seen = 16'h0;
  logic [7:0] rx_data_out;
  logic [7:0] last_rsp = 8'h00;
  logic [11:0] rx_count_out;
  int err_total = 0;
  int tests_run = 0;
  always #2 clock_in = ~clock_in;
  slc_line slc_line_inst (
    .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
    .msg_valid_in(msg_valid_in), .msg_in(msg_in),
    .msg_ready_out(msg_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_out(rsp_out), .mem_data_valid_in(mem_data_valid_in),
    .mem_data_in(mem_data_in), .mem_rd_out(mem_rd_out),
    .mem_addr_out(mem_addr_out), .rx_valid_out(rx_valid_out),
    .rx_data_out(rx_data_out), .rx_take_in(rx_take_in),
    .rx_count_out(rx_count_out), .rxd_in(rxd_in), .txd_out(txd_out)
  );
  slc_remote #(.BIT_CYC(BIT_CYC)) slc_remote_inst (
    .clock_in(clock_in), .txd_in(txd_out), .rxd_out(rxd_in)
  );
  // Shared memory answers each fetch one cycle later
  always @(posedge clock_in) begin
    mem_data_valid_in <= mem_rd_out && !mem_data_valid_in;
    mem_data_in <= mem_addr_out[7:0] + 8'hb0;
    if (mem_rd_out === 1'h1)
      addr_seen <= mem_addr_out;
  end
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Line 1 message, four argument bytes from byte 2, rest zero
  function automatic logic [127:0] mk(input logic [7:0] op,
                                      input logic [31:0] args);
    mk = {80'h0, args, 8'h01, op};
  endfunction
  // Holds the message until taken, then notes any response
  task automatic send(input logic [127:0] m);
    int n;
    n = 0;
    msg_valid_in <= 1'h1;
    msg_in <= m;
    do begin
      @(posedge clock_in);
      n++;
    end while (msg_ready_out !== 1'h1 && n < 100);
    msg_valid_in <= 1'h0;
    @(posedge clock_in);
    last_rsp = (rsp_valid_out === 1'h1) ? rsp_out[7:0] : 8'h00;
  endtask
  task automatic wait_rsp(input int lim);
    last_rsp = 8'h00;
    for (int i = 0; i < lim && last_rsp == 8'h00; i++) begin
      @(posedge clock_in);
      if (rsp_valid_out === 1'h1)
        last_rsp = rsp_out[7:0];
    end
  endtask
  task automatic pop(input logic [7:0] exp);
    rx_take_in <= 1'h1;
    @(posedge clock_in);
    rx_take_in <= 1'h0;
    @(posedge clock_in);
    check("rx byte", {8'h0, exp}, {8'h0, rx_data_out});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence: six bits, even parity, one stop, fastest rate
  initial begin
    repeat (12) @(posedge clock_in);
    rst_in <= 1'h0;
    @(posedge clock_in);
    check("txd idle", 16'h1, {15'h0, txd_out});
    check("rx count", 16'h0, {4'h0, rx_count_out});
    send(mk(SLC_OP_XMIT, 32'h00120001));
    send(mk(SLC_OP_ABORT, 32'h0));
    check("disabled xmit", 16'h0, {8'h0, last_rsp});
    send(mk(SLC_OP_ENABLE, 32'h0));
    send(mk(SLC_OP_ABORT, 32'h0));
    check("idle abort", 16'h0, {8'h0, last_rsp});
    send(mk(SLC_OP_SUSPEND, 32'h0));
    check("idle suspend", 16'h0, {8'h0, last_rsp});
    send(mk(SLC_OP_RESUME, 32'h0));
    check("idle resume", 16'h0, {8'h0, last_rsp});
    send(mk(SLC_OP_CONFIG, 32'h0102ffff));
    fork
      slc_remote_inst.send_frame(9'h055, 7, 1'h1);
      begin
        send(mk(SLC_OP_XMIT, 32'h00120001));
        wait_rsp(BIT_CYC * 10);
        check("xmit done", 16'h0001, {8'h0, last_rsp});
      end
    join
    check("fetch addr", 16'h0012, addr_seen);
    check("tx frame", 16'h0042, {8'h0, slc_remote_inst.rx_word});
    check("tx stop", 16'h1, {15'h0, slc_remote_inst.rx_stop});
    check("tx frames", 16'h1, slc_remote_inst.rx_cnt[15:0]);
    check("rx count", 16'h1, {4'h0, rx_count_out});
    pop(8'hd5);
    fork
      slc_remote_inst.send_frame(9'h055, 7, 1'h0);
      begin
        send(mk(SLC_OP_XMIT, 32'h00200002));
        repeat (1000) @(posedge clock_in);
        send(mk(SLC_OP_ABORT, 32'h0));
        check("abort rsp", 16'h0001, {8'h0, last_rsp});
      end
    join
    pop(8'h00);
    slc_remote_inst.send_frame(9'h015, 7, 1'h1);
    check("parity drop", 16'h0, {4'h0, rx_count_out});
    tally_and_finish();
  end
  // Cuts a hang short
  initial begin
    repeat (30 * BIT_CYC) @(posedge clock_in);
    err_total++;
    tally_and_finish();
  end
endmodule
bind slc_line slc_line_chk slc_line_chk_inst (
  .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
  .msg_valid_in(msg_valid_in), .msg_in(msg_in),
  .msg_ready_out(msg_ready_out), .rsp_valid_out(rsp_valid_out),
  .rsp_out(rsp_out), .mem_data_valid_in(mem_data_valid_in),
  .mem_rd_out(mem_rd_out), .rx_valid_out(rx_valid_out),
  .rx_count_out(rx_count_out), .txd_out(txd_out)
);
